// ### rtl/hpp_pkg.sv
// Constants and types for the host parallel port
package hpp_pkg;
  localparam logic [7:0] HPP_OFS_CTRL = 8'h00;
  localparam logic [7:0] HPP_OFS_IRQEN = 8'h04;
  localparam logic [7:0] HPP_OFS_STAT = 8'h08;
  localparam logic [7:0] HPP_CTRL_RST = 8'h90;
  localparam logic [7:0] HPP_IRQEN_RST = 8'h00;
  localparam logic [1:0] HPP_MODE_IDX = 2'h0;
  localparam logic [1:0] HPP_MODE_MUX = 2'h1;
  localparam logic [1:0] HPP_MODE_DEMUX = 2'h2;
  localparam logic [1:0] HPP_END_LITTLE = 2'h0;
  localparam logic [1:0] HPP_END_BIG = 2'h1;
  localparam logic [1:0] HPP_END_MIXED = 2'h2;
  localparam logic [2:0] HPP_HA_FIFO = 3'h6;
  localparam logic [2:0] HPP_T_FIFO = 3'h3;
  localparam logic [2:0] HPP_T_LIN = 3'h4;
  localparam logic [2:0] HPP_T_NONE = 3'h5;
  localparam logic [2:0] HPP_T_IDX = 3'h6;
  typedef struct packed {
    logic irq_pol;
    logic direct_map;
    logic dual_phase;
    logic width16;
    logic [1:0] endian;
    logic [1:0] mode;
  } hpp_cfg_type;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } hpp_creq_type;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ale_lo;
    logic ale_hi;
    logic end_sel;
    logic [15:0] addr;
    logic [15:0] data;
  } hpp_pins_type;
endpackage : hpp_pkg

// ### rtl/hpp_top.sv
// Host parallel port: pin decode, assemblers, FIFOs, APB config
module hpp_fifo2 #(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // Head and tail registers so both sides see flop outputs
  logic tail_v_r;
  logic [W-1:0] tail_r;
  logic push;
  logic pop;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      tail_v_r <= 1'b0;
      tail_r <= '0;
      in_ready <= 1'b1;
    end else begin
      if (!out_valid || (pop && !tail_v_r)) begin
        out_valid <= push;
        if (push) out_data <= in_data;
      end else if (pop) begin
        out_data <= tail_r;
        tail_v_r <= 1'b0;
        in_ready <= 1'b1;
      end else if (push) begin
        tail_r <= in_data;
        tail_v_r <= 1'b1;
        in_ready <= 1'b0;
      end
    end
  end
endmodule : hpp_fifo2

module hpp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hp_cs_n,
  input wire logic hp_rd_n,
  input wire logic hp_wr_n,
  input wire logic hp_ale_lo,
  input wire logic hp_ale_hi,
  input wire logic hp_end_sel,
  input wire logic [15:0] hp_addr,
  input wire logic [15:0] hp_data_i,
  output logic [15:0] hp_data_o,
  output logic hp_data_oe,
  output logic hp_wait,
  output logic hp_irq,
  output logic core_req_valid,
  output hpp_pkg::hpp_creq_type core_req,
  input wire logic core_ack,
  input wire logic [31:0] core_rdata,
  output logic core_rx_valid,
  input wire logic core_rx_ready,
  output logic [31:0] core_rx_data,
  input wire logic core_tx_valid,
  output logic core_tx_ready,
  input wire logic [31:0] core_tx_data,
  input wire logic [7:0] irq_src
);
  typedef enum {ST_IDLE, ST_RD, ST_WR, ST_PUSH, ST_POP} hpp_state_type;

  hpp_state_type st_r;
  hpp_pkg::hpp_cfg_type cfg_r;
  logic [7:0] irq_en_r;
  hpp_pkg::hpp_pins_type s1_r, s2_r, s3_r, pins;
  logic [15:0] mux_a_r;
  logic [15:0] idx_r [0:2];
  logic [31:0] buf_r [0:4];
  logic [3:0] mask_r [0:4];
  logic dir_r [0:4];
  logic [13:0] lin_a_r;
  logic [2:0] pt_r;
  logic [1:0] pl0_r, pl1_r;
  logic [3:0] pm_r;
  logic push_v_r;
  logic [31:0] push_d_r;
  logic tx_v, tx_pop;
  logic [31:0] tx_d;
  logic rx_in_ready;

  function automatic logic [1:0] lane(input logic [1:0] b, input logic [1:0] e);
    case (e)
      hpp_pkg::HPP_END_BIG: lane = b ^ 2'h3;
      hpp_pkg::HPP_END_MIXED: lane = b ^ 2'h2;
      default: lane = b;
    endcase
  endfunction : lane

  function automatic logic [15:0] pick(input logic [31:0] w, input logic [1:0] a,
                                       input logic [1:0] b, input logic w16);
    pick = {w16 ? w[b*8+:8] : 8'h00, w[a*8+:8]};
  endfunction : pick

  // Two-flop synchroniser plus an edge-detect flop on every host pin
  assign pins = '{cs_n: hp_cs_n, rd_n: hp_rd_n, wr_n: hp_wr_n, ale_lo: hp_ale_lo,
                  ale_hi: hp_ale_hi, end_sel: hp_end_sel, addr: hp_addr, data: hp_data_i};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      s2_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      s3_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic ev_rd, ev_wr, rd_end;
  assign ev_rd = s3_r.rd_n & ~s2_r.rd_n & ~s2_r.cs_n;
  // Write data sampled at strobe release, when it is surely settled
  assign ev_wr = ~s3_r.wr_n & s2_r.wr_n & ~s3_r.cs_n;
  assign rd_end = s2_r.rd_n | s2_r.cs_n;

  // address latch, one or two phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_a_r <= 16'h0000;
    end else if (cfg_r.mode == hpp_pkg::HPP_MODE_MUX) begin
      if (s3_r.ale_lo && !s2_r.ale_lo) begin
        if (cfg_r.dual_phase) mux_a_r[7:0] <= s2_r.data[7:0];
        else mux_a_r <= s2_r.data;
      end
      if (cfg_r.dual_phase && s3_r.ale_hi && !s2_r.ale_hi) mux_a_r[15:8] <= s2_r.data[7:0];
    end
  end

  // Access decode
  logic [15:0] ev_a;
  logic [1:0] ev_e, bo, l0, l1;
  logic [2:0] tgt;
  logic [1:0] pn;
  logic first, full;
  logic [3:0] lm, m_nxt;
  logic [31:0] wb_nxt;
  logic [15:0] caddr;
  always_comb begin
    ev_a = (cfg_r.mode == hpp_pkg::HPP_MODE_MUX) ? mux_a_r : s2_r.addr;
    ev_e = (cfg_r.mode == hpp_pkg::HPP_MODE_DEMUX) ? {1'b0, s2_r.end_sel} : cfg_r.endian;
    bo = {ev_a[1], ev_a[0] & ~cfg_r.width16};
    l0 = lane(bo, ev_e);
    l1 = lane(bo | 2'h1, ev_e);
    pn = ev_a[4:3];
    tgt = hpp_pkg::HPP_T_LIN;
    // direct mapping bypasses the index pairs
    if (cfg_r.mode == hpp_pkg::HPP_MODE_IDX && !cfg_r.direct_map) begin
      if (ev_a[4:2] == hpp_pkg::HPP_HA_FIFO) tgt = hpp_pkg::HPP_T_FIFO;
      else if (ev_a[4:2] > hpp_pkg::HPP_HA_FIFO || ev_a[15:5] != 11'h000) tgt = hpp_pkg::HPP_T_NONE;
      else if (!ev_a[2]) tgt = hpp_pkg::HPP_T_IDX;
      else tgt = {1'b0, pn};
    end
    lm = (4'h1 << l0) | (cfg_r.width16 ? (4'h1 << l1) : 4'h0);
    first = 1'b1;
    m_nxt = lm;
    wb_nxt = 32'h0000_0000;
    caddr = {ev_a[15:2], 2'b00};
    if (tgt < hpp_pkg::HPP_T_NONE) begin
      first = (mask_r[tgt] == 4'h0) || (dir_r[tgt] != ev_wr) ||
              (tgt == hpp_pkg::HPP_T_LIN && lin_a_r != ev_a[15:2]);
      m_nxt = (first ? 4'h0 : mask_r[tgt]) | lm;
      wb_nxt = buf_r[tgt];
      wb_nxt[l0*8+:8] = s2_r.data[7:0];
      if (cfg_r.width16) wb_nxt[l1*8+:8] = s2_r.data[15:8];
      if (tgt < hpp_pkg::HPP_T_FIFO) caddr = {idx_r[tgt[1:0]][15:2], 2'b00};
    end
    full = &m_nxt;
  end

  // Host access sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      for (int i = 0; i < 3; i++) idx_r[i] <= 16'h0000;
      for (int i = 0; i < 5; i++) begin
        buf_r[i] <= 32'h0000_0000;
        mask_r[i] <= 4'h0;
        dir_r[i] <= 1'b0;
      end
      lin_a_r <= 14'h0000;
      pt_r <= 3'h0;
      pl0_r <= 2'h0;
      pl1_r <= 2'h0;
      pm_r <= 4'h0;
      push_v_r <= 1'b0;
      push_d_r <= 32'h0000_0000;
      core_req_valid <= 1'b0;
      core_req <= '0;
      hp_data_o <= 16'h0000;
      hp_data_oe <= 1'b0;
      hp_wait <= 1'b0;
    end else begin
      if (rd_end) hp_data_oe <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (ev_rd || ev_wr) begin
            pt_r <= tgt;
            pl0_r <= l0;
            pl1_r <= l1;
            pm_r <= lm;
            if (tgt < hpp_pkg::HPP_T_NONE) dir_r[tgt] <= ev_wr;
            if (tgt == hpp_pkg::HPP_T_LIN) lin_a_r <= ev_a[15:2];
          end
          if (ev_wr) begin
            if (tgt == hpp_pkg::HPP_T_IDX) begin
              // only the addressed pair's index moves
              if (l0 < 2'h2) idx_r[pn][l0*8+:8] <= s2_r.data[7:0];
              if (cfg_r.width16 && l1 < 2'h2) idx_r[pn][l1*8+:8] <= s2_r.data[15:8];
            end else if (tgt < hpp_pkg::HPP_T_NONE) begin
              buf_r[tgt] <= wb_nxt;
              mask_r[tgt] <= full ? 4'h0 : m_nxt;
              if (full && tgt == hpp_pkg::HPP_T_FIFO) begin
                push_d_r <= wb_nxt;
                push_v_r <= 1'b1;
                hp_wait <= 1'b1;
                st_r <= ST_PUSH;
              end else if (full) begin
                core_req <= '{we: 1'b1, addr: caddr, wdata: wb_nxt};
                core_req_valid <= 1'b1;
                hp_wait <= 1'b1;
                st_r <= ST_WR;
              end
            end
          end else if (ev_rd) begin
            hp_data_oe <= 1'b1;
            if (tgt == hpp_pkg::HPP_T_IDX) begin
              hp_data_o <= pick({16'h0000, idx_r[pn]}, l0, l1, cfg_r.width16);
            end else if (tgt == hpp_pkg::HPP_T_NONE) begin
              hp_data_o <= 16'h0000;
            end else if (first) begin
              hp_wait <= 1'b1;
              if (tgt == hpp_pkg::HPP_T_FIFO) begin
                st_r <= ST_POP;
              end else begin
                core_req <= '{we: 1'b0, addr: caddr, wdata: 32'h0000_0000};
                core_req_valid <= 1'b1;
                st_r <= ST_RD;
              end
            end else begin
              hp_data_o <= pick(buf_r[tgt], l0, l1, cfg_r.width16);
              mask_r[tgt] <= full ? 4'h0 : m_nxt;
            end
          end
        end
        ST_RD: begin
          if (core_ack) begin
            core_req_valid <= 1'b0;
            buf_r[pt_r] <= core_rdata;
            mask_r[pt_r] <= pm_r;
            hp_data_o <= pick(core_rdata, pl0_r, pl1_r, cfg_r.width16);
            hp_wait <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        ST_POP: begin
          if (tx_v) begin
            buf_r[pt_r] <= tx_d;
            mask_r[pt_r] <= pm_r;
            hp_data_o <= pick(tx_d, pl0_r, pl1_r, cfg_r.width16);
            hp_wait <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        ST_WR: begin
          if (core_ack) begin
            core_req_valid <= 1'b0;
            hp_wait <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        ST_PUSH: begin
          // Full FIFO holds the host in wait, no word dropped
          if (rx_in_ready) begin
            push_v_r <= 1'b0;
            hp_wait <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // process data FIFOs, one per direction
  hpp_fifo2 #(.W(32)) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_v_r),
    .in_ready(rx_in_ready),
    .in_data(push_d_r),
    .out_valid(core_rx_valid),
    .out_ready(core_rx_ready),
    .out_data(core_rx_data)
  );
  assign tx_pop = (st_r == ST_POP);
  logic tx_in_ready;
  hpp_fifo2 #(.W(32)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(core_tx_valid),
    .in_ready(tx_in_ready),
    .in_data(core_tx_data),
    .out_valid(tx_v),
    .out_ready(tx_pop),
    .out_data(tx_d)
  );
  assign core_tx_ready = tx_in_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hp_irq <= 1'b0;
    else hp_irq <= ~(|(irq_src & irq_en_r) ^ cfg_r.irq_pol);
  end

  // APB slave, answers in the cycle after setup
  logic acc;
  assign acc = psel & ~penable & ~pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= hpp_pkg::HPP_CTRL_RST;
      irq_en_r <= hpp_pkg::HPP_IRQEN_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      if (acc) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          hpp_pkg::HPP_OFS_CTRL: begin
            if (pwrite) cfg_r <= pwdata[7:0];
            else prdata <= {24'h000000, cfg_r};
          end
          hpp_pkg::HPP_OFS_IRQEN: begin
            if (pwrite) irq_en_r <= pwdata[7:0];
            else prdata <= {24'h000000, irq_en_r};
          end
          hpp_pkg::HPP_OFS_STAT: begin
            pslverr <= pwrite;
            prdata <= {16'h0000, irq_src, 4'h0, tx_v, core_rx_valid, push_v_r, st_r != ST_IDLE};
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : hpp_top

// ### verification/hpp_props.sv
// Concurrent checks on the host parallel port top-level ports
module hpp_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hp_cs_n,
  input wire logic hp_rd_n,
  input wire logic hp_data_oe,
  input wire logic hp_wait,
  input wire logic core_req_valid,
  input wire hpp_pkg::hpp_creq_type core_req,
  input wire logic core_ack,
  input wire logic core_rx_valid,
  input wire logic core_rx_ready,
  input wire logic [31:0] core_rx_data,
  input wire logic [7:0] irq_src,
  input wire logic hp_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  stat_write_a: assert property (psel && !penable && pwrite && paddr == hpp_pkg::HPP_OFS_STAT |=> pslverr)
    else $error("status write not refused");
  req_stable_a: assert property (core_req_valid && !core_ack |=> core_req_valid && $stable(core_req))
    else $error("core request changed before ack");
  req_release_a: assert property (core_ack |=> !core_req_valid)
    else $error("core request held after ack");
  req_wait_a: assert property (core_req_valid |-> hp_wait)
    else $error("host not held during core access");
  rx_hold_a: assert property (core_rx_valid && !core_rx_ready |=> core_rx_valid && $stable(core_rx_data))
    else $error("receive word lost under stall");
  oe_read_a: assert property ($rose(hp_data_oe) |-> !hp_rd_n && !hp_cs_n)
    else $error("data driven outside a read");
  oe_drop_a: assert property (hp_rd_n [*5] |-> !hp_data_oe)
    else $error("data still driven after read");
  irq_level_a: assert property ((!psel && $stable(irq_src)) [*3] |-> $stable(hp_irq))
    else $error("interrupt moved with steady sources");
endmodule : hpp_props

bind hpp_top hpp_props i_props (.*);

// ### verification/hpp_host_model.sv
// Host processor model driving the parallel port pins
module hpp_host_model (
  input wire logic pclk,
  input wire logic [15:0] hp_data_o,
  input wire logic hp_data_oe,
  input wire logic hp_wait,
  output hpp_pkg::hpp_pins_type pins,
  output logic tmo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pins = {3'h7, 35'h0};
    tmo = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask : hold
  // Sampled at the rising edge, the values the design itself sees there
  task automatic poll(input logic rd, output logic [15:0] q);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((hp_wait !== 1'b0 || (rd && hp_data_oe !== 1'b1)) && n < 400);
    q = hp_data_o;
    tmo <= tmo | (n >= 400);
  endtask : poll
  // address latched on the strobe's falling edge
  task automatic ale(input logic hi, input logic [15:0] v);
    pins.data <= v;
    pins.ale_lo <= !hi;
    pins.ale_hi <= hi;
    hold(3);
    pins.ale_lo <= 1'b0;
    pins.ale_hi <= 1'b0;
    hold(3);
  endtask : ale
  // address and byte order held over the whole cycle
  task automatic cyc(input int mux, input logic we, input logic es, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    logic [15:0] t;
    if (mux > 0) ale(1'b0, a);
    if (mux > 1) ale(1'b1, {a[15:8], a[15:8]});
    pins.cs_n <= 1'b0;
    pins.addr <= a;
    pins.end_sel <= es;
    pins.data <= we ? d : ~pins.data;
    hold(1);
    pins.wr_n <= !we;
    pins.rd_n <= we;
    hold(5);
    poll(!we, q);
    pins.wr_n <= 1'b1;
    pins.rd_n <= 1'b1;
    hold(6);
    poll(1'b0, t);
    pins.cs_n <= 1'b1;
    hold(3);
  endtask : cyc
endmodule : hpp_host_model

// ### verification/host_bus_interface_modes_tb.sv
// Self-checking bench for the host parallel port
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module host_bus_interface_modes_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hp_data_oe, hp_wait, hp_irq;
  logic core_req_valid, core_rx_valid, core_tx_ready, host_tmo, hang = 1'b0;
  logic core_ack = 1'b0, core_rx_ready = 1'b0, core_tx_valid = 1'b0;
  logic [7:0] paddr, irq_src;
  logic [31:0] pwdata, prdata, core_rx_data, rt, core_rdata = 32'h0, core_tx_data = 32'h0;
  logic [15:0] hp_data_o;
  hpp_pkg::hpp_creq_type core_req;
  hpp_pkg::hpp_pins_type pins;
  int seed = 63, err_total = 0, n_checks = 0, n_wr = 0, n_rd = 0, stall = 0, m, w, en;
  logic [31:0] mem [int];
  logic [31:0] rxq [$], txq [$], txe [$];
  hpp_top i_dut (.*, .hp_cs_n(pins.cs_n), .hp_rd_n(pins.rd_n), .hp_wr_n(pins.wr_n), .hp_ale_lo(pins.ale_lo),
    .hp_ale_hi(pins.ale_hi), .hp_end_sel(pins.end_sel), .hp_addr(pins.addr),
    .hp_data_i(hp_data_oe ? hp_data_o : pins.data));
  hpp_host_model i_host (.pclk, .hp_data_o, .hp_data_oe, .hp_wait, .pins, .tmo(host_tmo));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Core side: slow random acks, random receive stalls
  always @(posedge pclk) begin
    core_ack <= 1'b0;
    core_rx_ready <= 1'($random(seed));
    if (core_req_valid === 1'b1 && !core_ack && $random(seed) % 2 == 0) begin
      core_ack <= 1'b1;
      if (core_req.we) mem[core_req.addr[15:2]] = core_req.wdata;
      core_rdata <= mem[core_req.addr[15:2]];
      n_wr += core_req.we;
      n_rd += !core_req.we;
    end
    if (core_rx_valid === 1'b1 && core_rx_ready) begin
      rt = rxq.pop_front();
      `CHK(core_rx_data, rt)
    end
    if (core_tx_valid && core_tx_ready === 1'b1) void'(txq.pop_front());
    stall += (core_tx_valid && core_tx_ready === 1'b0);
    core_tx_valid <= txq.size() > 0;
    core_tx_data <= (txq.size() > 0) ? txq[0] : 32'h0;
  end
  always @(posedge pclk) if (hang || host_tmo === 1'b1) begin
    err_total++;
    results();
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hang <= hang | (n >= 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Byte lane of address b under the current order
  task automatic part(input logic we, input logic [15:0] a, input logic [31:0] wd, input int b,
                      inout logic [31:0] rd);
    int l0, l1;
    logic [15:0] q;
    l0 = 8 * (b ^ ((en == 1) ? 3 : en));
    l1 = 8 * ((b | 1) ^ ((en == 1) ? 3 : en));
    i_host.cyc((m == 1) ? w + 1 : 0, we, en == 1, a + 16'(b), {wd[l1 +: 8], wd[l0 +: 8]}, q);
    if (!we) rd[l0 +: 8] = q[7:0];
    if (!we && w) rd[l1 +: 8] = q[15:8];
  endtask : part
  task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd);
    rd = 32'h0;
    for (int b = 0; b < 4; b += w + 1) part(we, a, wd, b, rd);
  endtask : xfer
  initial begin
    logic [31:0] q, d0, d1, d2, r0, r1;
    logic e;
    logic [15:0] ia;
    int nw, nr;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, irq_src} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, hpp_pkg::HPP_OFS_CTRL, 32'h0, q, e);
    `CHK(q[7:0], hpp_pkg::HPP_CTRL_RST)
    apb(1'b0, hpp_pkg::HPP_OFS_IRQEN, 32'h0, q, e);
    `CHK(q[7:0], hpp_pkg::HPP_IRQEN_RST)
    apb(1'b1, hpp_pkg::HPP_OFS_STAT, 32'h0, q, e);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h0C, 32'h0, q, e);
    `CHK(e, 1'b1)
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, hpp_pkg::HPP_OFS_CTRL, {24'h0, 1'(p / 2), 7'h10}, q, e);
      apb(1'b1, hpp_pkg::HPP_OFS_IRQEN, 32'h5A, q, e);
      irq_src <= 8'($random(seed));
      repeat (4) @(posedge pclk);
      `CHK(hp_irq, (p > 1) == |(irq_src & 8'h5A))
    end
    for (m = 0; m < 3; m++) for (w = 0; w < 2; w++) for (en = 0; en < 3 - m / 2; en++) begin
      d0 = $random(seed);
      d1 = $random(seed);
      d2 = $random(seed);
      ia = 16'($random(seed)) & 16'hFFFC;
      apb(1'b1, hpp_pkg::HPP_OFS_CTRL, {24'h0, 2'h2, w[0], w[0], en[1:0], m[1:0]}, q, e);
      if (m == 0) begin
        // index first, then its data register
        xfer(1'b1, 16'h0, {16'h0, ia}, q);
        xfer(1'b1, 16'h8, {16'h0, ia ^ 16'h0040}, q);
        nw = n_wr;
        rxq.push_back(d2);
        for (int b = 0; b < 4; b += w + 1) begin
          part(1'b1, 16'h4, d0, b, q);
          part(1'b1, 16'hC, d1, b, q);
          part(1'b1, 16'h18, d2, b, q);
        end
        `CHK(n_wr - nw, 2)
        `CHK(mem[ia[15:2]], d0)
        `CHK(mem[ia[15:2] ^ 14'h10], d1)
        nr = n_rd;
        r0 = 32'h0;
        r1 = 32'h0;
        for (int b = 0; b < 4; b += w + 1) begin
          part(1'b0, 16'h4, 32'h0, b, r0);
          part(1'b0, 16'hC, 32'h0, b, r1);
        end
        `CHK(n_rd - nr, 2)
        `CHK(r0, d0)
        `CHK(r1, d1)
        xfer(1'b0, 16'h0, 32'h0, r0);
        `CHK(r0, {16'h0, ia})
      end else begin
        nw = n_wr;
        xfer(1'b1, ia, d0, q);
        `CHK(n_wr - nw, 1)
        `CHK(mem[ia[15:2]], d0)
        xfer(1'b0, ia, 32'h0, r0);
        `CHK(r0, d0)
      end
    end
    m = 0;
    w = 1;
    en = 0;
    apb(1'b1, hpp_pkg::HPP_OFS_CTRL, 32'h0000_00D0, q, e);
    // address beyond the pair map reaches the core directly
    ia = (16'($random(seed)) & 16'hFFFC) | 16'h0100;
    d0 = $random(seed);
    nw = n_wr;
    xfer(1'b1, ia, d0, q);
    `CHK(n_wr - nw, 1)
    `CHK(mem[ia[15:2]], d0)
    xfer(1'b0, ia, 32'h0, r0);
    `CHK(r0, d0)
    apb(1'b1, hpp_pkg::HPP_OFS_CTRL, {24'h0, hpp_pkg::HPP_CTRL_RST}, q, e);
    for (int i = 0; i < 4; i++) begin
      d0 = $random(seed);
      txq.push_back(d0);
      txe.push_back(d0);
    end
    repeat (20) @(posedge pclk);
    `CHK(stall > 0, 1'b1)
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 16'h18, 32'h0, r0);
      r1 = txe.pop_front();
      `CHK(r0, r1)
    end
    // every word pushed by the host reached the core
    `CHK(rxq.size(), 0)
    results();
  end
endmodule : host_bus_interface_modes_tb
